// ==== common/pwrseq_pkg.sv ====
// Purpose: shared constants for the power sequence and scroll control link
// Assumes: 200 MHz mclk, command bytes carried with the data/command line low
// Notes:   times are kept in their printed units, cycle counts derived
package pwrseq_pkg;

  localparam int unsigned clk_mhz = 200;

  // command bytes
  localparam logic [7:0] cmd_scroll_right = 8'h26;
  localparam logic [7:0] cmd_scroll_left  = 8'h27;
  localparam logic [7:0] cmd_scroll_stop  = 8'h2e;
  localparam logic [7:0] cmd_scroll_start = 8'h2f;
  localparam logic [7:0] cmd_sleep_out    = 8'h11;
  localparam logic [7:0] cmd_display_off  = 8'hae;
  localparam logic [7:0] cmd_display_on   = 8'haf;
  localparam logic [7:0] cmd_lock         = 8'hfd;

  // a lock command carries one data byte; bit 2 locks
  localparam int unsigned lock_bit = 2;

  // timing figures, printed units
  localparam int unsigned vdd_settle_ms          = 1;
  localparam int unsigned reset_pulse_time_us    = 2;
  localparam int unsigned reset_to_panel_us      = 2;
  localparam int unsigned drive_enable_delay_ms  = 200;
  localparam int unsigned supply_off_delay_ms    = 80;

  // derived cycle counts; all minimums, exact multiples of the period
  localparam int unsigned vdd_settle_cyc     = vdd_settle_ms * clk_mhz * 1000;
  localparam int unsigned reset_pulse_cyc    = reset_pulse_time_us * clk_mhz;
  localparam int unsigned reset_to_panel_cyc = reset_to_panel_us * clk_mhz;
  localparam int unsigned drive_enable_cyc   =
    drive_enable_delay_ms * clk_mhz * 1000;
  localparam int unsigned supply_off_cyc     =
    supply_off_delay_ms * clk_mhz * 1000;

  // column counter width for the scroll offset
  localparam int unsigned col_w = 7;
  // mclk cycles between two scroll steps (plain default)
  localparam int unsigned scroll_step_cyc = 16;

  localparam logic [31:0] cnt_zero = 32'h0;

endpackage : pwrseq_pkg

// ==== common/pwrseq_if.sv ====
// Purpose: pins between host sequencer and display driver
// Assumes: single clock, all pins sampled synchronously
// Notes:   supplies are modelled as enable levels
`timescale 1ns/1ps
interface pwrseq_if;
  logic       logic_supply;      // logic supply enable
  logic       interface_supply;  // interface supply enable
  logic       core_input_supply; // panel supply enable
  logic       reset_n_pin;       // active-low reset
  logic       cmd_valid;         // one-cycle byte strobe
  logic       dc;                // 0 = command, 1 = data
  logic [7:0] data;              // byte

  modport host (
    output logic_supply, interface_supply, core_input_supply,
    output reset_n_pin, cmd_valid, dc, data
  );
  modport device (
    input logic_supply, interface_supply, core_input_supply,
    input reset_n_pin, cmd_valid, dc, data
  );
endinterface : pwrseq_if

// ==== design/pwrseq_device.sv ====
// Purpose: display driver end: reset, sleep, lock and scroll state
// Assumes: host obeys supply ordering and command/data signalling
// Notes:   scroll offset steps one column every scroll_step_cyc cycles
`timescale 1ns/1ps
module pwrseq_device (
  pwrseq_if.device   link,
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  output logic       drivers_on,
  output logic       display_on,
  output logic       scrolling,
  output logic       scroll_left,
  output logic       locked,
  output logic [6:0] scroll_offset
);

  logic        drivers_on_r;
  logic        display_on_r;
  logic        scroll_on_r;
  logic        dir_left_r;
  logic        setup_seen_r;
  logic        locked_r;
  logic        lock_arg_r;
  logic [6:0]  offset_r;
  logic [31:0] wake_cnt_r;
  logic        waking_r;
  logic [31:0] step_cnt_r;
  logic        cmd;
  logic        in_reset;

  // commands count only when not locked, except the lock itself
  assign in_reset = sys_rst | ~link.reset_n_pin;
  assign cmd      = link.cmd_valid & ~link.dc;

  // lock: the next byte after a lock command sets or clears it
  always_ff @(posedge mclk) begin
    if (in_reset) begin
      locked_r   <= 1'b0;
      lock_arg_r <= 1'b0;
    end else if (link.cmd_valid) begin
      if (lock_arg_r) begin
        locked_r   <= link.data[pwrseq_pkg::lock_bit];
        lock_arg_r <= 1'b0;
      end else if (cmd && link.data == pwrseq_pkg::cmd_lock) begin
        lock_arg_r <= 1'b1;
      end
    end
  end

  // sleep / display on, with the drive enable delay after sleep-out
  always_ff @(posedge mclk) begin
    if (in_reset) begin
      display_on_r <= 1'b0;  // reset leaves the device asleep
      drivers_on_r <= 1'b0;
      waking_r     <= 1'b0;
      wake_cnt_r   <= pwrseq_pkg::cnt_zero;
    end else begin
      if (cmd && !locked_r && !lock_arg_r) begin
        unique case (link.data)
          pwrseq_pkg::cmd_display_off: begin
            display_on_r <= 1'b0;
            drivers_on_r <= 1'b0;
            waking_r     <= 1'b0;
          end
          pwrseq_pkg::cmd_display_on: display_on_r <= 1'b1;
          pwrseq_pkg::cmd_sleep_out: begin
            waking_r   <= 1'b1;
            wake_cnt_r <= pwrseq_pkg::cnt_zero;
          end
          default: ;
        endcase
      end else if (waking_r) begin
        if (wake_cnt_r == 32'(pwrseq_pkg::drive_enable_cyc - 1)) begin
          drivers_on_r <= 1'b1;
          waking_r     <= 1'b0;
        end else begin
          wake_cnt_r <= wake_cnt_r + 32'h1;
        end
      end
    end
  end

  // scroll setup, start and stop
  always_ff @(posedge mclk) begin
    if (in_reset) begin
      scroll_on_r  <= 1'b0;
      dir_left_r   <= 1'b0;
      setup_seen_r <= 1'b0;
    end else if (cmd && !locked_r && !lock_arg_r) begin
      unique case (link.data)
        pwrseq_pkg::cmd_scroll_right: begin
          dir_left_r   <= 1'b0;
          setup_seen_r <= 1'b1;
        end
        pwrseq_pkg::cmd_scroll_left: begin
          dir_left_r   <= 1'b1;
          setup_seen_r <= 1'b1;
        end
        pwrseq_pkg::cmd_scroll_stop: scroll_on_r <= 1'b0;
        // host pairs start with a setup; ignore a start before any setup since reset
        pwrseq_pkg::cmd_scroll_start:
          scroll_on_r <= setup_seen_r;
        default: ;
      endcase
    end
  end

  // one column per step in the chosen direction
  always_ff @(posedge mclk) begin
    if (in_reset || !scroll_on_r) begin
      step_cnt_r <= pwrseq_pkg::cnt_zero;
      if (in_reset) offset_r <= 7'h00;
    end else if (step_cnt_r == 32'(pwrseq_pkg::scroll_step_cyc - 1)) begin
      step_cnt_r <= pwrseq_pkg::cnt_zero;
      offset_r   <= dir_left_r ? offset_r - 7'h01 : offset_r + 7'h01;
    end else begin
      step_cnt_r <= step_cnt_r + 32'h1;
    end
  end

  // outputs straight from flops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      drivers_on    <= 1'b0;
      display_on    <= 1'b0;
      scrolling     <= 1'b0;
      scroll_left   <= 1'b0;
      locked        <= 1'b0;
      scroll_offset <= 7'h00;
    end else begin
      drivers_on    <= drivers_on_r & display_on_r;
      display_on    <= display_on_r;
      scrolling     <= scroll_on_r;
      scroll_left   <= dir_left_r;
      locked        <= locked_r;
      scroll_offset <= offset_r;
    end
  end

endmodule : pwrseq_device

// ==== design/pwrseq_host.sv ====
// Purpose: host sequencer: power up, reset, sleep-out, scroll, power down
// Assumes: start/stop requests are pulses; one byte per cycle at most
// Notes:   every wait is a minimum counted on mclk, so none falls short
//
// Overview of operation
// - stop command halts configured scrolling
// - host rewrites memory after scroll stop; this host only raises rewrite_needed for it
// - start command scrolls per latest setup
// - start only right after a setup
// - wait 1 ms before reset low
// - reset low at least 2 us
// - panel supply 2 us after reset low
// - registers default by reset end
// - sleep-out after panel supply; drivers 200 ms
// - display off before panel supply off
// - wait 80 ms before logic supply off
// - never drop logic before panel supply
// - setup picks scroll direction, one column
// - display off sleeps, on runs
// - lock blocks all but lock command
`timescale 1ns/1ps
module pwrseq_host #(
  parameter int unsigned vdd_settle_cyc = pwrseq_pkg::vdd_settle_cyc,
  parameter int unsigned supply_off_cyc = pwrseq_pkg::supply_off_cyc
) (
  pwrseq_if.host     link,
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  input  wire logic  power_up_req,
  input  wire logic  power_down_req,
  input  wire logic  scroll_req,
  input  wire logic  scroll_dir_left,
  input  wire logic  scroll_stop_req,
  output logic       ready,
  output logic       rewrite_needed
);

  // one state per sequence step; off takes power-up, run takes the other requests
  typedef enum {
    st_off, st_settle, st_rst_low, st_panel_wait, st_rst_hold,
    st_wake, st_on_cmd, st_run, st_scroll_start, st_disp_off,
    st_panel_off, st_off_wait
  } host_state_e;

  host_state_e state_r;
  logic [31:0] cnt_r;

  // step events, decoded once and shared by the update blocks
  logic        up_go;        // power-up request taken
  logic        settle_done;  // logic supply has settled
  logic        panel_due;    // reset low long enough for panel supply
  logic        hold_done;    // reset pulse long enough to release
  logic        down_go;      // power-down request taken
  logic        stop_go;      // scroll stop request taken
  logic        scroll_go;    // scroll setup request taken
  logic        off_done;     // panel supply off long enough

  // timed events; each wait ends on its last whole cycle
  assign up_go       = (state_r == st_off) && power_up_req;
  assign settle_done = (state_r == st_settle) &&
                       (cnt_r == 32'(vdd_settle_cyc - 1));
  assign panel_due   = (state_r == st_rst_low) &&
                       (cnt_r == 32'(pwrseq_pkg::reset_to_panel_cyc - 1));
  assign hold_done   = (state_r == st_rst_hold) &&
                       (cnt_r >= 32'(pwrseq_pkg::reset_pulse_cyc - 1));
  assign off_done    = (state_r == st_panel_off) &&
                       (cnt_r == 32'(supply_off_cyc - 1));

  // requests count only in run; power-down outranks scroll stop,
  // which outranks scroll setup
  assign down_go     = (state_r == st_run) && power_down_req;
  assign stop_go     = (state_r == st_run) && !power_down_req &&
                       scroll_stop_req;
  assign scroll_go   = (state_r == st_run) && !power_down_req &&
                       !scroll_stop_req && scroll_req;

  // sequence steps; timed steps leave on their counter events,
  // so a slow request never shortens a wait
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= st_off;
    end else begin
      unique case (state_r)
        st_off:          if (up_go) state_r <= st_settle;
        st_settle:       if (settle_done) state_r <= st_rst_low;
        st_rst_low:      if (panel_due) state_r <= st_rst_hold;
        st_rst_hold:     if (hold_done) state_r <= st_panel_wait;
        st_panel_wait:   state_r <= st_wake;
        st_wake:         state_r <= st_on_cmd;
        st_on_cmd:       state_r <= st_run;
        st_run: begin
          if (down_go) begin
            state_r <= st_disp_off;
          end else if (scroll_go) begin
            state_r <= st_scroll_start;
          end
        end
        st_scroll_start: state_r <= st_run;
        st_disp_off:     state_r <= st_panel_off;
        st_panel_off:    if (off_done) state_r <= st_off_wait;
        st_off_wait:     state_r <= st_off;
      endcase
    end
  end

  // one free counter serves every wait; restarted as each wait begins,
  // which costs nothing: only the panel and pulse waits overlap, both timed from reset low
  always_ff @(posedge mclk) begin
    if (sys_rst || up_go || settle_done || state_r == st_disp_off) begin
      cnt_r <= pwrseq_pkg::cnt_zero;
    end else begin
      cnt_r <= cnt_r + 32'h1;  // waits are whole cycles, never short
    end
  end

  // supply enables; panel supply only inside the logic supply window
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      link.logic_supply      <= 1'b0;
      link.interface_supply  <= 1'b0;
      link.core_input_supply <= 1'b0;
    end else begin
      if (up_go) begin
        link.logic_supply     <= 1'b1;
        link.interface_supply <= 1'b1;
      end else if (off_done) begin
        link.logic_supply     <= 1'b0;
        link.interface_supply <= 1'b0;
      end

      // panel supply follows the reset pin and the display-off byte
      if (panel_due) begin
        link.core_input_supply <= 1'b1;
      end else if (state_r == st_disp_off) begin
        link.core_input_supply <= 1'b0;  // panel off after display off
      end
    end
  end

  // reset pin: lowered after the settle wait, raised after the pulse;
  // the panel supply comes up while it is still low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      link.reset_n_pin <= 1'b1;
    end else if (settle_done) begin
      link.reset_n_pin <= 1'b0;
    end else if (hold_done) begin
      link.reset_n_pin <= 1'b1;
    end
  end

  // command bytes, one per cycle; data holds its last byte when idle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      link.cmd_valid <= 1'b0;
      link.dc        <= 1'b1;
      link.data      <= 8'h00;
    end else begin
      link.cmd_valid <= 1'b0;
      link.dc        <= 1'b0;  // command bytes only
      // sequence steps first; requests only arrive in run
      if (state_r == st_panel_wait) begin
        link.cmd_valid <= 1'b1;  // sleep-out once panel is up
        link.data      <= pwrseq_pkg::cmd_sleep_out;
      end else if (state_r == st_wake) begin
        link.cmd_valid <= 1'b1;
        link.data      <= pwrseq_pkg::cmd_display_on;
      end else if (state_r == st_scroll_start) begin
        link.cmd_valid <= 1'b1;  // start directly after setup
        link.data      <= pwrseq_pkg::cmd_scroll_start;
      end else if (down_go) begin
        link.cmd_valid <= 1'b1;
        link.data      <= pwrseq_pkg::cmd_display_off;
      end else if (stop_go) begin
        link.cmd_valid <= 1'b1;
        link.data      <= pwrseq_pkg::cmd_scroll_stop;
      end else if (scroll_go) begin
        link.cmd_valid <= 1'b1;
        link.data      <= scroll_dir_left ?
                          pwrseq_pkg::cmd_scroll_left :
                          pwrseq_pkg::cmd_scroll_right;
      end
    end
  end

  // ready only in run; dropped while a setup and start pair goes out,
  // so no request can split the pair
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ready <= 1'b0;
    end else if (state_r == st_on_cmd || state_r == st_scroll_start) begin
      ready <= 1'b1;
    end else if (down_go || scroll_go) begin
      ready <= 1'b0;
    end
  end

  // memory contents are lost once scrolling stops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rewrite_needed <= 1'b0;
    end else if (stop_go) begin
      rewrite_needed <= 1'b1;  // memory must be redrawn
    end else if (scroll_go) begin
      rewrite_needed <= 1'b0;
    end
  end

endmodule : pwrseq_host

// ==== verif/pwrseq_monitor.sv ====
// Purpose: wire-level watch of the host to display driver link
// Assumes: one clock domain, sys_rst synchronous and active high
// Notes:   wait bounds are the minimums in whole cycles, no slack
`timescale 1ns/1ps
module pwrseq_monitor #(
  parameter int unsigned vdd_settle_cyc = pwrseq_pkg::vdd_settle_cyc,
  parameter int unsigned supply_off_cyc = pwrseq_pkg::supply_off_cyc
) (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       logic_supply,
  input wire logic       interface_supply,
  input wire logic       core_input_supply,
  input wire logic       reset_n_pin,
  input wire logic       cmd_valid,
  input wire logic       dc,
  input wire logic [7:0] data
);
  logic [31:0] up_cnt_r;
  logic [31:0] low_cnt_r;
  logic [31:0] off_cnt_r;
  logic        off_sent_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // cycles since the logic supply came up
  always_ff @(posedge mclk) begin
    up_cnt_r <= (sys_rst || !logic_supply) ? 32'h0 : up_cnt_r + 32'h1;
  end

  // cycles that reset has been held low
  always_ff @(posedge mclk) begin
    low_cnt_r <= (sys_rst || reset_n_pin) ? 32'h0 : low_cnt_r + 32'h1;
  end

  // cycles since the panel supply went off
  always_ff @(posedge mclk) begin
    off_cnt_r <= (sys_rst || core_input_supply) ? 32'h0 : off_cnt_r + 32'h1;
  end

  // display-off seen since the last sleep-out; guards panel switch-off
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      off_sent_r <= 1'b0;
    end else if (cmd_valid && data == pwrseq_pkg::cmd_display_off) begin
      off_sent_r <= 1'b1;
    end else if (cmd_valid && data == pwrseq_pkg::cmd_sleep_out) begin
      off_sent_r <= 1'b0;
    end
  end

  a_cmd_select_low: assert property (cmd_valid |-> !dc)
    else $error("command byte sent with data select high");
  a_settle_before_reset: assert property (
    $fell(reset_n_pin) && logic_supply |-> up_cnt_r >= vdd_settle_cyc)
    else $error("reset lowered before logic supply settled");
  a_reset_pulse_len: assert property (
    $rose(reset_n_pin) |-> low_cnt_r >= pwrseq_pkg::reset_pulse_cyc)
    else $error("reset pulse too short");
  a_panel_after_reset: assert property (
    $rose(core_input_supply)
    |-> low_cnt_r >= pwrseq_pkg::reset_to_panel_cyc)
    else $error("panel supply on too soon after reset low");
  a_sleep_out_order: assert property (
    cmd_valid && data == pwrseq_pkg::cmd_sleep_out
    |-> core_input_supply && reset_n_pin)
    else $error("sleep-out sent before panel supply");
  a_scroll_start_pair: assert property (
    cmd_valid && data == pwrseq_pkg::cmd_scroll_start
    |-> $past(cmd_valid) && ($past(data) == pwrseq_pkg::cmd_scroll_right ||
        $past(data) == pwrseq_pkg::cmd_scroll_left))
    else $error("scroll start not right after a setup");
  a_display_off_first: assert property (
    $fell(core_input_supply) |-> off_sent_r)
    else $error("panel supply off without display off");
  a_logic_off_wait: assert property (
    $fell(logic_supply) |-> off_cnt_r >= supply_off_cyc)
    else $error("logic supply dropped too soon");
  a_supply_order: assert property (
    core_input_supply |-> logic_supply && interface_supply)
    else $error("panel supply on without logic supplies");
endmodule : pwrseq_monitor

// ==== verif/power_sequence_scroll_ctrl_test.sv ====
// Purpose: host and driver ends joined, scenarios judged at both sides
// Assumes: settle and switch-off waits shortened to 20 cycles
// Notes:   the 200 ms drive enable is too long to run; only its absence
`timescale 1ns/1ps
module power_sequence_scroll_ctrl_test;
  localparam int unsigned settle_cyc = 20;
  localparam int unsigned off_cyc    = 20;
  logic       mclk;
  logic       sys_rst;
  logic       power_up_req;
  logic       power_down_req;
  logic       scroll_req;
  logic       scroll_dir_left;
  logic       scroll_stop_req;
  logic       ready;
  logic       rewrite_needed;
  logic       drivers_on;
  logic       display_on;
  logic       scrolling;
  logic       scroll_left;
  logic       locked;
  logic [6:0] scroll_offset;
  int         fail_count;
  int         compares;
  int         cycles;

  pwrseq_if link ();
  pwrseq_host #(.vdd_settle_cyc(settle_cyc), .supply_off_cyc(off_cyc))
    i_pwrseq_host (.link(link), .mclk, .sys_rst, .power_up_req,
    .power_down_req, .scroll_req, .scroll_dir_left, .scroll_stop_req,
    .ready, .rewrite_needed);
  pwrseq_device i_pwrseq_device (.link(link), .mclk, .sys_rst,
    .drivers_on, .display_on, .scrolling, .scroll_left, .locked,
    .scroll_offset);
  pwrseq_monitor #(.vdd_settle_cyc(settle_cyc), .supply_off_cyc(off_cyc))
    i_pwrseq_monitor (.mclk, .sys_rst,
    .logic_supply(link.logic_supply),
    .interface_supply(link.interface_supply),
    .core_input_supply(link.core_input_supply),
    .reset_n_pin(link.reset_n_pin), .cmd_valid(link.cmd_valid),
    .dc(link.dc), .data(link.data));

  // free-running 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // hang guard; whole run needs about a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  // one-cycle request; bits are stop, scroll, down, up
  task automatic request(input logic [3:0] sel);
    @(posedge mclk);
    {scroll_stop_req, scroll_req, power_down_req, power_up_req} <= sel;
    @(posedge mclk);
    {scroll_stop_req, scroll_req, power_down_req, power_up_req} <= 4'h0;
    repeat (2) @(posedge mclk);
    #1;
    while (ready !== 1'b1 && sel != 4'h2) begin
      @(posedge mclk);
      #1;
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask : request

  task automatic t_power_up();
    request(4'h1);
    chk({7'h0, display_on}, 8'h01);
    chk({7'h0, drivers_on}, 8'h00);
    chk({7'h0, link.reset_n_pin}, 8'h01);
    chk({7'h0, locked}, 8'h00);
    chk({1'b0, scroll_offset}, 8'h00);
    chk({7'h0, scrolling}, 8'h00);
  endtask : t_power_up

  task automatic t_scroll(input logic left);
    logic [6:0] first;
    @(posedge mclk);
    scroll_dir_left <= left;
    request(4'h4);
    chk({7'h0, scrolling}, 8'h01);
    chk({7'h0, scroll_left}, {7'h0, left});
    chk({7'h0, rewrite_needed}, 8'h00);
    first = scroll_offset;
    repeat (pwrseq_pkg::scroll_step_cyc) @(posedge mclk);
    #1;
    chk({1'b0, scroll_offset - first}, left ? 8'h7f : 8'h01);
  endtask : t_scroll

  task automatic t_scroll_stop();
    logic [6:0] held;
    request(4'h8);
    chk({7'h0, scrolling}, 8'h00);
    chk({7'h0, rewrite_needed}, 8'h01);
    held = scroll_offset;
    repeat (40) @(posedge mclk);
    #1;
    chk({1'b0, scroll_offset}, {1'b0, held});
  endtask : t_scroll_stop

  task automatic t_power_down();
    request(4'h2);
    while (link.logic_supply !== 1'b0) begin
      @(posedge mclk);
      #1;
    end
    chk({7'h0, display_on}, 8'h00);
    chk({7'h0, link.core_input_supply}, 8'h00);
    chk({7'h0, ready}, 8'h00);
    repeat (4) @(posedge mclk);
  endtask : t_power_down

  // main sequence; scrolling left running across power down, cleared by the power-up reset
  initial begin
    {power_up_req, power_down_req, scroll_req} = 3'h0;
    {scroll_dir_left, scroll_stop_req} = 2'h0;
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_power_up();
    t_scroll(1'b0);
    t_scroll(1'b1);
    t_scroll_stop();
    t_scroll(1'b1);
    t_power_down();
    t_power_up();
    chk({7'h0, scroll_left}, 8'h00);
    stop_test();
  end
endmodule : power_sequence_scroll_ctrl_test
